/* File: verilog/fwp_pkg.sv */
package fwp_pkg;
    localparam int CLK_MHZ = 200;
    localparam int POWER_ON_WAIT_US = 70;
    localparam int POWER_ON_WAIT_CYC = POWER_ON_WAIT_US * CLK_MHZ;
    localparam int ERASE_RESUME_GAP_US = 100;
    localparam int PROGRAM_RESUME_GAP_NS = 300;
    localparam int PROGRAM_RESUME_GAP_CYC = (PROGRAM_RESUME_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int ERASE_RESUME_GAP_CYC = ERASE_RESUME_GAP_US * CLK_MHZ;
    localparam int RESUME_GAP_CYC = (ERASE_RESUME_GAP_CYC > PROGRAM_RESUME_GAP_CYC) ?
        ERASE_RESUME_GAP_CYC : PROGRAM_RESUME_GAP_CYC;
    localparam logic [15:0] SCLK_HALF_CYC = 16'h0004;
    localparam logic [15:0] DESELECT_CYC = 16'h0008;
    localparam logic [7:0] CMD_WRITE_ALLOW = 8'h06;
    localparam logic [7:0] CMD_WRITE_DENY = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h81;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hD8;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
    localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'h60;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    localparam logic [7:0] CMD_SUSPEND = 8'h75;
    localparam logic [7:0] CMD_RESUME = 8'h7A;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_PROT_LSB = 2;
    localparam int SR_LOCK0_BIT = 7;
    localparam int SR2_LOCK1_BIT = 0;
    localparam int SR2_INVERT_BIT = 6;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [15:0] USED_RESET = 16'h0000;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_LEN_LSB = 1;
    localparam int CTRL_USE_ADDR_BIT = 5;
    localparam int CTRL_OP_LSB = 8;
    localparam int CTRL_PROTECT_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_POWERED_BIT = 1;
    localparam int STAT_WEL_SENT_BIT = 2;
    localparam int STAT_RX_LSB = 8;
    typedef enum logic [2:0] {
        OP_PAGE_ERASE = 3'h0,
        OP_SECTOR_ERASE = 3'h1,
        OP_BLOCK32_ERASE = 3'h2,
        OP_BLOCK64_ERASE = 3'h3,
        OP_CHIP_ERASE = 3'h4,
        OP_PROGRAM = 3'h5
    } fwp_op_e;
    typedef enum logic [6:0] {
        H_POWER = 7'h01,
        H_IDLE = 7'h02,
        H_SETUP = 7'h04,
        H_LOW = 7'h08,
        H_HIGH = 7'h10,
        H_HOLD = 7'h20,
        H_DESEL = 7'h40
    } fwp_host_state_e;
endpackage : fwp_pkg

/* File: verilog/fwp_if.sv */
interface fwp_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic protect_n;
    modport dev (
        input sclk,
        input cs_n,
        input mosi,
        input protect_n,
        output miso
    );
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        output protect_n,
        input miso
    );
endinterface : fwp_if

/* File: verilog/fwp_device.sv */
module fwp_device (
    input wire logic pclk,
    input wire logic presetn,
    fwp_if.dev link,
    output logic arr_req,
    output fwp_pkg::fwp_op_e arr_kind,
    output logic [19:0] arr_addr,
    output logic cmd_reject,
    output logic [15:0] status_word,
    output logic [15:0] used_map,
    output logic deep_sleep
);
    typedef struct packed {
        logic [6:0] sh;
        logic [2:0] bitcnt;
        logic [3:0] bytecnt;
        logic [7:0] op;
        logic [23:0] addr;
        logic [7:0] d1;
        logic [7:0] d2;
        logic frame_tog;
        logic [7:0] sr_s1;
        logic [7:0] sr_s2;
    } fwp_link_s;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
        logic wp_s1;
        logic wp_s2;
        logic [4:0] prot;
        logic inv;
        logic lock0;
        logic lock1;
        logic write_latch;
        logic sleep;
        logic [15:0] used;
        logic req;
        fwp_pkg::fwp_op_e kind;
        logic [19:0] addr;
        logic rej;
    } fwp_core_s;

    fwp_link_s lk;
    fwp_link_s next_lk;
    fwp_core_s cr;
    fwp_core_s next_cr;
    logic armed;
    logic miso_q;

    function automatic logic prot_hit(logic [4:0] p, logic inv, logic [7:0] lo, logic [7:0] hi);
        logic [8:0] cnt;
        logic bottom;
        logic [9:0] top_sum;
        cnt = 9'h000;
        if (!p[4])
        begin
            unique case (p[2:0])
                3'h0: cnt = 9'h000;
                3'h1: cnt = 9'h010;
                3'h2: cnt = 9'h020;
                3'h3: cnt = 9'h040;
                3'h4: cnt = 9'h080;
                default: cnt = 9'h100;
            endcase
        end
        else
        begin
            unique case (p[2:0])
                3'h0: cnt = 9'h000;
                3'h1: cnt = 9'h001;
                3'h2: cnt = 9'h002;
                3'h3: cnt = 9'h004;
                3'h4, 3'h5: cnt = 9'h008;
                default: cnt = 9'h100;
            endcase
        end
        bottom = p[3];
        if (inv)
        begin
            cnt = 9'h100 - cnt;
            bottom = ~bottom;
        end
        top_sum = {2'h0, hi} + {1'h0, cnt};
        prot_hit = (cnt != 9'h000) &&
            (bottom ? ({1'h0, lo} < cnt) : (top_sum >= 10'h100));
    endfunction : prot_hit

    // link side: shift in on rising sclk
    always_comb
    begin
        logic [2:0] bc;
        logic [3:0] yc;
        logic [7:0] byte_v;
        bc = armed ? lk.bitcnt : 3'h0;
        yc = armed ? lk.bytecnt : 4'h0;
        byte_v = {lk.sh, link.mosi};
        next_lk = lk;
        next_lk.sh = byte_v[6:0];
        next_lk.bitcnt = 3'(bc + 3'h1);
        next_lk.bytecnt = yc;
        next_lk.sr_s1 = status_word[7:0];
        next_lk.sr_s2 = lk.sr_s1;
        if (!armed)
        begin
            next_lk.frame_tog = ~lk.frame_tog;
        end
        if (bc == 3'h7)
        begin
            next_lk.bytecnt = (yc == 4'hF) ? yc : 4'(yc + 4'h1);
            unique case (yc)
                4'h0: next_lk.op = byte_v;
                4'h1:
                begin
                    next_lk.addr[23:16] = byte_v;
                    next_lk.d1 = byte_v;
                end
                4'h2:
                begin
                    next_lk.addr[15:8] = byte_v;
                    next_lk.d2 = byte_v;
                end
                4'h3: next_lk.addr[7:0] = byte_v;
                default: next_lk.addr = lk.addr;
            endcase
        end
    end

    always_ff @(posedge link.sclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lk <= '0;
        end
        else
        begin
            lk <= next_lk;
        end
    end

    // cleared while deselected so each frame restarts its counters
    always_ff @(posedge link.sclk or posedge link.cs_n)
    begin
        if (link.cs_n)
        begin
            armed <= 1'b0;
        end
        else
        begin
            armed <= 1'b1;
        end
    end

    always_ff @(negedge link.sclk or negedge presetn)
    begin
        if (!presetn)
        begin
            miso_q <= 1'b0;
        end
        else
        begin
            miso_q <= (lk.op == fwp_pkg::CMD_READ_STATUS && lk.bytecnt != 4'h0) ?
                lk.sr_s2[~lk.bitcnt] : 1'b0;
        end
    end
    assign link.miso = miso_q;

    // core side: judge the finished frame once cs_n is seen high
    always_comb
    begin
        logic done;
        logic ok_len;
        logic change;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] sec;
        fwp_pkg::fwp_op_e kind;
        next_cr = cr;
        next_cr.cs_s1 = link.cs_n;
        next_cr.cs_s2 = cr.cs_s1;
        next_cr.cs_prev = cr.cs_s2;
        next_cr.tog_s1 = lk.frame_tog;
        next_cr.tog_s2 = cr.tog_s1;
        next_cr.wp_s1 = link.protect_n;
        next_cr.wp_s2 = cr.wp_s1;
        next_cr.req = 1'b0;
        next_cr.rej = 1'b0;
        sec = lk.addr[19:12];
        lo = sec;
        hi = sec;
        kind = fwp_pkg::OP_PROGRAM;
        ok_len = 1'b0;
        change = 1'b1;
        done = cr.cs_s2 && !cr.cs_prev && (cr.tog_s2 != cr.tog_seen);
        unique case (lk.op)
            fwp_pkg::CMD_PAGE_ERASE:
            begin
                kind = fwp_pkg::OP_PAGE_ERASE;
                ok_len = lk.bytecnt == 4'h4;
            end
            fwp_pkg::CMD_SECTOR_ERASE:
            begin
                kind = fwp_pkg::OP_SECTOR_ERASE;
                ok_len = lk.bytecnt == 4'h4;
            end
            fwp_pkg::CMD_BLOCK32_ERASE:
            begin
                kind = fwp_pkg::OP_BLOCK32_ERASE;
                ok_len = lk.bytecnt == 4'h4;
                lo = {sec[7:3], 3'h0};
                hi = {sec[7:3], 3'h7};
            end
            fwp_pkg::CMD_BLOCK64_ERASE:
            begin
                kind = fwp_pkg::OP_BLOCK64_ERASE;
                ok_len = lk.bytecnt == 4'h4;
                lo = {sec[7:4], 4'h0};
                hi = {sec[7:4], 4'hF};
            end
            fwp_pkg::CMD_CHIP_ERASE, fwp_pkg::CMD_CHIP_ERASE_ALT:
            begin
                kind = fwp_pkg::OP_CHIP_ERASE;
                ok_len = lk.bytecnt == 4'h1;
                lo = 8'h00;
                hi = 8'hFF;
            end
            fwp_pkg::CMD_PAGE_PROGRAM: ok_len = lk.bytecnt >= 4'h5;
            fwp_pkg::CMD_WRITE_STATUS: ok_len = lk.bytecnt == 4'h2 || lk.bytecnt == 4'h3;
            fwp_pkg::CMD_READ_STATUS:
            begin
                change = 1'b0;
                ok_len = lk.bytecnt != 4'h0;
            end
            default:
            begin
                change = 1'b0;
                ok_len = lk.bytecnt == 4'h1;
            end
        endcase
        if (done)
        begin
            next_cr.tog_seen = cr.tog_s2;
            if (lk.bitcnt != 3'h0 || !ok_len)
            begin
                next_cr.rej = 1'b1;
            end
            else if (cr.sleep)
            begin
                next_cr.rej = lk.op != fwp_pkg::CMD_WAKE;
                next_cr.sleep = lk.op != fwp_pkg::CMD_WAKE;
            end
            else if (change && !cr.write_latch)
            begin
                next_cr.rej = 1'b1;
            end
            else if (lk.op == fwp_pkg::CMD_WRITE_STATUS)
            begin
                next_cr.write_latch = 1'b0;
                if (cr.wp_s2)
                begin
                    next_cr.prot = lk.d1[fwp_pkg::SR_PROT_LSB +: 5];
                    next_cr.lock0 = lk.d1[fwp_pkg::SR_LOCK0_BIT];
                end
                if (lk.bytecnt == 4'h3)
                begin
                    next_cr.inv = lk.d2[fwp_pkg::SR2_INVERT_BIT];
                    if (cr.wp_s2)
                    begin
                        next_cr.lock1 = lk.d2[fwp_pkg::SR2_LOCK1_BIT];
                    end
                end
            end
            else if (change)
            begin
                if (prot_hit(cr.prot, cr.inv, lo, hi))
                begin
                    next_cr.rej = 1'b1;
                end
                else
                begin
                    next_cr.write_latch = 1'b0;
                    next_cr.req = 1'b1;
                    next_cr.kind = kind;
                    next_cr.addr = lk.addr[19:0];
                    if (kind == fwp_pkg::OP_PROGRAM)
                    begin
                        next_cr.used[lk.addr[19:16]] = 1'b1;
                    end
                    else if (kind == fwp_pkg::OP_CHIP_ERASE)
                    begin
                        next_cr.used = fwp_pkg::USED_RESET;
                    end
                    else if (kind == fwp_pkg::OP_BLOCK64_ERASE)
                    begin
                        next_cr.used[lk.addr[19:16]] = 1'b0;
                    end
                end
            end
            else
            begin
                unique case (lk.op)
                    fwp_pkg::CMD_WRITE_ALLOW: next_cr.write_latch = 1'b1;
                    fwp_pkg::CMD_WRITE_DENY: next_cr.write_latch = 1'b0;
                    fwp_pkg::CMD_DEEP_SLEEP: next_cr.sleep = 1'b1;
                    fwp_pkg::CMD_READ_STATUS, fwp_pkg::CMD_WAKE: next_cr.rej = 1'b0;
                    default: next_cr.rej = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cr <= '0;
            cr.cs_s1 <= 1'b1;
            cr.cs_s2 <= 1'b1;
            cr.cs_prev <= 1'b1;
        end
        else
        begin
            cr <= next_cr;
        end
    end

    assign arr_req = cr.req;
    assign arr_kind = cr.kind;
    assign arr_addr = cr.addr;
    assign cmd_reject = cr.rej;
    assign status_word = {cr.inv, 6'h00, cr.lock1, cr.lock0, cr.prot, cr.write_latch, 1'b0};
    assign used_map = cr.used;
    assign deep_sleep = cr.sleep;
endmodule : fwp_device

/* File: verilog/fwp_host.sv */
module fwp_host #(
    parameter int POWER_WAIT_CYC = fwp_pkg::POWER_ON_WAIT_CYC,
    parameter int RESUME_WAIT_CYC = fwp_pkg::RESUME_GAP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    fwp_if.host link
);
    typedef struct packed {
        fwp_pkg::fwp_host_state_e st;
        logic [15:0] cnt;
        logic [15:0] gap;
        logic [6:0] nbits;
        logic [6:0] bitidx;
        logic [63:0] tx;
        logic [7:0] cur_op;
        logic [7:0] rx;
        logic miso_s1;
        logic miso_s2;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic wp_n;
        logic [7:0] op;
        logic [3:0] len;
        logic use_addr;
        logic [23:0] addr;
        logic [31:0] data;
        logic busy;
        logic wel_sent;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fwp_hst_s;

    fwp_hst_s hs;
    fwp_hst_s next_hs;

    function automatic logic is_change(logic [7:0] op);
        is_change = op == fwp_pkg::CMD_WRITE_STATUS || op == fwp_pkg::CMD_PAGE_ERASE ||
            op == fwp_pkg::CMD_SECTOR_ERASE || op == fwp_pkg::CMD_BLOCK32_ERASE ||
            op == fwp_pkg::CMD_BLOCK64_ERASE || op == fwp_pkg::CMD_CHIP_ERASE ||
            op == fwp_pkg::CMD_CHIP_ERASE_ALT || op == fwp_pkg::CMD_PAGE_PROGRAM;
    endfunction : is_change

    always_comb
    begin
        logic setup;
        logic wr;
        logic half;
        next_hs = hs;
        setup = psel && !penable;
        wr = psel && penable && hs.pready && pwrite;
        half = hs.cnt == fwp_pkg::SCLK_HALF_CYC - 16'h0001;
        next_hs.miso_s1 = link.miso;
        next_hs.miso_s2 = hs.miso_s1;
        next_hs.pready = setup;
        next_hs.pslverr = setup && paddr > fwp_pkg::REG_STATUS;
        next_hs.cnt = 16'(hs.cnt + 16'h0001);
        if (hs.gap != 16'h0000)
        begin
            next_hs.gap = 16'(hs.gap - 16'h0001);
        end
        if (setup)
        begin
            unique case (paddr)
                fwp_pkg::REG_CTRL: next_hs.prdata = {15'h0000, hs.wp_n, hs.op, 2'h0,
                    hs.use_addr, hs.len, 1'b0};
                fwp_pkg::REG_ADDR: next_hs.prdata = {8'h00, hs.addr};
                fwp_pkg::REG_DATA: next_hs.prdata = hs.data;
                fwp_pkg::REG_STATUS: next_hs.prdata = {16'h0000, hs.rx, 5'h00, hs.wel_sent,
                    hs.st != fwp_pkg::H_POWER, hs.busy};
                default: next_hs.prdata = 32'h0000_0000;
            endcase
        end
        if (wr && paddr == fwp_pkg::REG_CTRL)
        begin
            next_hs.wp_n = pwdata[fwp_pkg::CTRL_PROTECT_BIT];
            if (!hs.busy && pwdata[fwp_pkg::CTRL_GO_BIT] &&
                pwdata[fwp_pkg::CTRL_LEN_LSB +: 4] != 4'h0)
            begin
                next_hs.busy = 1'b1;
                next_hs.len = pwdata[fwp_pkg::CTRL_LEN_LSB +: 4];
                next_hs.use_addr = pwdata[fwp_pkg::CTRL_USE_ADDR_BIT];
                next_hs.op = pwdata[fwp_pkg::CTRL_OP_LSB +: 8];
            end
        end
        if (wr && !hs.busy && paddr == fwp_pkg::REG_ADDR)
        begin
            next_hs.addr = pwdata[23:0];
        end
        if (wr && !hs.busy && paddr == fwp_pkg::REG_DATA)
        begin
            next_hs.data = pwdata;
        end
        unique case (hs.st)
            fwp_pkg::H_POWER:
            begin
                if (hs.cnt == 16'(POWER_WAIT_CYC - 1))
                begin
                    next_hs.st = fwp_pkg::H_IDLE;
                end
            end
            fwp_pkg::H_IDLE:
            begin
                next_hs.cnt = 16'h0000;
                if (hs.busy && is_change(hs.op) && !hs.wel_sent)
                begin
                    next_hs.st = fwp_pkg::H_SETUP;
                    next_hs.tx = {fwp_pkg::CMD_WRITE_ALLOW, 56'h0};
                    next_hs.nbits = 7'h08;
                end
                else if (hs.busy && (hs.op != fwp_pkg::CMD_SUSPEND || hs.gap == 16'h0000))
                begin
                    next_hs.st = fwp_pkg::H_SETUP;
                    next_hs.tx = hs.use_addr ? {hs.op, hs.addr, hs.data} :
                        {hs.op, hs.data, 24'h0};
                    next_hs.nbits = {hs.len, 3'h0};
                end
                next_hs.cur_op = next_hs.tx[63:56];
                next_hs.bitidx = 7'h00;
            end
            fwp_pkg::H_SETUP:
            begin
                next_hs.cs_n = 1'b0;
                next_hs.mosi = hs.tx[63];
                if (half)
                begin
                    next_hs.st = fwp_pkg::H_LOW;
                    next_hs.cnt = 16'h0000;
                end
            end
            fwp_pkg::H_LOW:
            begin
                if (half)
                begin
                    next_hs.rx = {hs.rx[6:0], hs.miso_s2};
                    next_hs.sclk = 1'b1;
                    next_hs.st = fwp_pkg::H_HIGH;
                    next_hs.cnt = 16'h0000;
                end
            end
            fwp_pkg::H_HIGH:
            begin
                if (half)
                begin
                    next_hs.sclk = 1'b0;
                    next_hs.tx = {hs.tx[62:0], 1'b0};
                    next_hs.mosi = hs.tx[62];
                    next_hs.bitidx = 7'(hs.bitidx + 7'h01);
                    next_hs.cnt = 16'h0000;
                    next_hs.st = (7'(hs.bitidx + 7'h01) == hs.nbits) ?
                        fwp_pkg::H_HOLD : fwp_pkg::H_LOW;
                end
            end
            fwp_pkg::H_HOLD:
            begin
                if (half)
                begin
                    next_hs.cs_n = 1'b1;
                    next_hs.mosi = 1'b0;
                    next_hs.cnt = 16'h0000;
                    next_hs.st = fwp_pkg::H_DESEL;
                    if (hs.cur_op == fwp_pkg::CMD_WRITE_ALLOW)
                    begin
                        next_hs.wel_sent = 1'b1;
                    end
                    else if (is_change(hs.cur_op))
                    begin
                        next_hs.wel_sent = 1'b0;
                    end
                    if (hs.cur_op == hs.op)
                    begin
                        next_hs.busy = 1'b0;
                    end
                    if (hs.cur_op == fwp_pkg::CMD_RESUME)
                    begin
                        next_hs.gap = 16'(RESUME_WAIT_CYC);
                    end
                end
            end
            fwp_pkg::H_DESEL:
            begin
                if (hs.cnt == fwp_pkg::DESELECT_CYC - 16'h0001)
                begin
                    next_hs.st = fwp_pkg::H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hs <= '0;
            hs.st <= fwp_pkg::H_POWER;
            hs.cs_n <= 1'b1;
            hs.wp_n <= 1'b1;
        end
        else
        begin
            hs <= next_hs;
        end
    end

    assign prdata = hs.prdata;
    assign pready = hs.pready;
    assign pslverr = hs.pslverr;
    assign link.sclk = hs.sclk;
    assign link.cs_n = hs.cs_n;
    assign link.mosi = hs.mosi;
    assign link.protect_n = hs.wp_n;
endmodule : fwp_host

/* File: verification/fwp_chk.sv */
module fwp_chk #(
    parameter int POWER_WAIT_CYC = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic protect_n,
    input wire logic arr_req,
    input wire logic [15:0] status_word,
    input wire logic [15:0] used_map,
    input wire logic deep_sleep
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pc;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // cycles since reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc <= 16'h0000;
        else if (pc != 16'hFFFF)
            pc <= pc + 16'h0001;
    end
    chk_sclk_idle : assert property (cs_n |-> !sclk) else $error("sclk moves deselected");
    chk_desel_gap : assert property ($rose(cs_n) |=> cs_n [*3]) else $error("deselect short");
    chk_power_wait : assert property (int'(pc) < POWER_WAIT_CYC - 2 |-> cs_n)
        else $error("selected too early");
    chk_latch_use : assert property (arr_req |-> $past(status_word[1]))
        else $error("change without latch");
    chk_sleep_gate : assert property (deep_sleep |-> !arr_req)
        else $error("change while asleep");
    chk_pin_lock : assert property (!protect_n && !$past(protect_n, 8) |=>
        $stable(status_word[8:2])) else $error("protect bits moved");
    chk_all_locked : assert property (arr_req |-> status_word[15] ||
        status_word[4:3] != 2'b11) else $error("change in locked array");
    chk_reset_clear : assert property (!$past(presetn) |->
        status_word == 16'h0000 && used_map == 16'h0000 && !deep_sleep)
        else $error("bad reset state");
endmodule : fwp_chk

/* File: verification/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, arr_req, cmd_reject, ds, acc, rej;
    logic [19:0] arr_addr;
    logic [15:0] sw, um;
    int bad_count = 0, n_compared = 0, cyc = 0;
    fwp_if lk();
    fwp_host #(.POWER_WAIT_CYC(50), .RESUME_WAIT_CYC(80)) fwp_host_i (.pclk, .presetn,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr(), .link(lk));
    fwp_device fwp_device_i (.pclk, .presetn, .link(lk), .arr_req, .arr_kind(), .arr_addr,
        .cmd_reject, .status_word(sw), .used_map(um), .deep_sleep(ds));
    fwp_chk #(.POWER_WAIT_CYC(50)) fwp_chk_i (.pclk, .presetn, .sclk(lk.sclk),
        .cs_n(lk.cs_n), .protect_n(lk.protect_n), .arr_req, .status_word(sw),
        .used_map(um), .deep_sleep(ds));
    always #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (arr_req)
            acc <= 1'b1;
        if (cmd_reject)
            rej <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            bad_count++;
            end_sim;
        end
    end
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // address phase for frames of four bytes or more
    task automatic frame(input logic [7:0] op, input logic [3:0] n, input logic [23:0] ad,
        input logic [31:0] d, input logic pn);
        apb(1'b1, 8'h04, {8'h00, ad});
        apb(1'b1, 8'h08, d);
        acc = 1'b0;
        rej = 1'b0;
        apb(1'b1, 8'h00, {15'h0, pn, op, 2'h0, n > 4'h3, n, 1'b1});
        do apb(1'b0, 8'h0C, 32'h0); while (q[0] !== 1'b0);
        // verdict pulses trail the cs_n rise by a few cycles
        repeat (8) @(posedge pclk);
    endtask : frame
    task automatic t_reset;
        chk("status", 32'h0, {16'h0, sw});
        chk("blank map", 32'h0, {16'h0, um});
        do apb(1'b0, 8'h0C, 32'h0); while (q[1] !== 1'b1);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_prot;
        frame(8'h01, 4'h2, 24'h0, 32'h4400_0000, 1'b1);
        chk("prot bits", 32'h11, {27'h0, sw[6:2]});
        frame(8'hD8, 4'h4, 24'h0F0000, 32'h0, 1'b1);
        chk("span reject", 32'h1, {31'h0, rej});
        frame(8'h20, 4'h4, 24'h0FE000, 32'h0, 1'b1);
        chk("accept", 32'h1, {31'h0, acc});
        chk("addr", 32'h0FE000, {12'h0, arr_addr});
        $display("t_prot done");
    endtask : t_prot
    task automatic t_inv;
        frame(8'h01, 4'h3, 24'h0, 32'h0440_0000, 1'b1);
        chk("invert", 32'h1, {31'h0, sw[15]});
        frame(8'h20, 4'h4, 24'h0EF000, 32'h0, 1'b1);
        chk("low reject", 32'h1, {31'h0, rej});
        frame(8'h20, 4'h4, 24'h0F0000, 32'h0, 1'b1);
        chk("top accept", 32'h1, {31'h0, acc});
        $display("t_inv done");
    endtask : t_inv
    task automatic t_pin;
        frame(8'h01, 4'h3, 24'h0, 32'h0, 1'b0);
        chk("held bits", 32'h01, {27'h0, sw[6:2]});
        chk("invert off", 32'h0, {31'h0, sw[15]});
        $display("t_pin done");
    endtask : t_pin
    task automatic t_sleep;
        frame(8'hB9, 4'h1, 24'h0, 32'h0, 1'b1);
        chk("asleep", 32'h1, {31'h0, ds});
        frame(8'h20, 4'h4, 24'h0, 32'h0, 1'b1);
        chk("sleep reject", 32'h0, {31'h0, acc});
        frame(8'hAB, 4'h1, 24'h0, 32'h0, 1'b1);
        chk("awake", 32'h0, {31'h0, ds});
        $display("t_sleep done");
    endtask : t_sleep
    task automatic t_prog;
        frame(8'h02, 4'h5, 24'h010000, 32'hA500_0000, 1'b1);
        chk("program", 32'h1, {31'h0, acc});
        chk("used map", 32'h2, {16'h0, um});
        frame(8'hC7, 4'h1, 24'h0, 32'h0, 1'b1);
        chk("chip reject", 32'h1, {31'h0, rej});
        frame(8'hD8, 4'h4, 24'h010000, 32'h0, 1'b1);
        chk("erased map", 32'h0, {16'h0, um});
        frame(8'h05, 4'h2, 24'h0, 32'h0, 1'b1);
        chk("status byte", 32'h04, {24'h0, q[15:8]});
        frame(8'h20, 4'h2, 24'h0, 32'h0, 1'b1);
        chk("short frame", 32'h1, {31'h0, rej});
        chk("short kept", 32'h0, {31'h0, acc});
        $display("t_prog done");
    endtask : t_prog
    initial
    begin
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_prot;
        t_inv;
        t_pin;
        t_sleep;
        t_prog;
        end_sim;
    end
endmodule : tb
